// file: rtl/csb_pkg.sv
package csb_pkg;

  localparam int          CSB_ADDR_W            = 16;
  localparam int          CSB_DATA_W            = 8;
  // security register sits at the top of the loader area space
  localparam logic [15:0] CSB_SEC_ADDR          = 16'hffff;
  // block control, status and identity, placed just below the security register
  localparam logic [15:0] CSB_CTRL_ADDR         = 16'hfffe;
  localparam logic [15:0] CSB_STAT_ADDR         = 16'hfffd;
  localparam logic [15:0] CSB_MAKER_ADDR        = 16'hfffc;
  localparam logic [15:0] CSB_PART_ADDR         = 16'hfffb;
  // security field positions
  localparam int          CSB_BIT_LOCK          = 0;
  localparam int          CSB_BIT_CRI           = 1;
  localparam int          CSB_BIT_SCR           = 2;
  localparam int          CSB_BIT_OSC           = 7;
  // control field positions
  localparam int          CSB_CTL_PROG          = 0;
  localparam int          CSB_CTL_ERASE         = 1;
  // erased state: every security bit is one
  localparam logic [7:0]  CSB_SEC_RESET         = 8'hff;
  localparam logic [7:0]  CSB_ZERO8             = 8'h00;
  // arbitrary identity values
  localparam logic [7:0]  CSB_MAKER_ID_DEF      = 8'h5a;
  localparam logic [7:0]  CSB_PART_ID_DEF       = 8'ha5;
  // scramble key, arbitrary
  localparam logic [7:0]  CSB_SCRAMBLE_KEY      = 8'h3c;
  // straps are sampled when the settle count reaches this value, on the fifth edge after reset release
  localparam logic [1:0]  CSB_STRAP_SETTLE      = 2'd3;

  typedef enum logic [1:0] {CSB_ST_RESET, CSB_ST_SETTLE, CSB_ST_RUN} csb_state_t;

endpackage : csb_pkg

// file: rtl/csb_sync2.sv
`timescale 1ns/1ps
module csb_sync2 #(
  parameter int W = 3
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_r;

  // straps idle high, so the chain presets to the non-forcing level
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      meta_r <= '1;
      dout   <= '1;
    end
    else
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule : csb_sync2

// file: rtl/csb_code_security_boot_select.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Loader boot is chosen when both low straps are low, or when the force strap is low.
// - Without a forcing strap combination the device boots from the main program area.
// - Straps are evaluated at reset; the system must hold them at non-forcing levels.
// - Before locking, programming mode may program and read back the store freely.
// - Special setting registers are unreachable through programming-mode accesses.
// - Security bits only go from one to zero; only erase-all sets them again.
// - Maker and part identity values are fixed and cannot be written.
// - The security register sits at address 0xffff of the loader area.
// - With the lock bit at zero, store and special register accesses are refused.
// - With code read inhibit at zero, code reads from external fetch go external only.
// - Code reads from internal fetch may always reach internal and external memory.
// - With code read inhibit at one, code reads are unrestricted.
// - With scrambling enabled, port 0 data pass through encoding logic.
// - The scramble enable returns inactive only through whole-chip erase.
// - Oscillator gain is halved when bit 7 is zero, full when it is one.
module csb_code_security_boot_select
  import csb_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = CSB_MAKER_ID_DEF,  // arbitrary value
  parameter logic [7:0] PART_ID  = CSB_PART_ID_DEF    // arbitrary value
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  // strap pins
  input  wire logic        boot_strap_force,
  input  wire logic        boot_strap_b,
  input  wire logic        boot_strap_a,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // programming-mode store access from the device programmer
  input  wire logic        prog_req,
  input  wire logic        prog_is_special,
  output logic             prog_grant,
  // code-space read steering
  input  wire logic        code_rd_req,
  input  wire logic        code_rd_from_ext,
  input  wire logic        code_rd_target_int,
  output logic             code_rd_internal,
  // port 0 data path
  input  wire logic [7:0]  port0_data_in,
  output logic      [7:0]  port0_data_out,
  // status outputs
  output logic             loader_boot_mode,
  output logic             osc_gain_half,
  output logic             boot_valid
);

  logic [2:0]  strap_sync;
  csb_state_t  state_r;
  logic [1:0]  settle_r;
  logic [7:0]  sec_r;
  logic        prog_mode_r;
  logic        loader_boot_r;
  logic        sampled_r;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  // loader boot when the force strap is low or both low straps are low
  function automatic logic loader_pick(input logic [2:0] s);
    loader_pick = ~s[2] | (~s[1] & ~s[0]);
  endfunction : loader_pick

  csb_sync2 #(.W(3)) csb_sync2_i (
    .mclk  (mclk),
    .reset (reset),
    .din   ({boot_strap_force, boot_strap_b, boot_strap_a}),
    .dout  (strap_sync)
  );

  // straps pass the synchroniser before they are caught; settle gives it time to fill
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_r  <= CSB_ST_RESET;
      settle_r <= '0;
    end
    else
    begin
      unique case (state_r)
        CSB_ST_RESET:
        begin
          state_r  <= CSB_ST_SETTLE;
          settle_r <= '0;
        end
        CSB_ST_SETTLE:
        begin
          settle_r <= settle_r + 2'd1;
          if (settle_r == CSB_STRAP_SETTLE)
            state_r <= CSB_ST_RUN;
        end
        CSB_ST_RUN:
          state_r <= CSB_ST_RUN;
        default:
          state_r <= CSB_ST_RESET;
      endcase
    end
  end

  // strap capture once per reset; later pin motion is ignored
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      loader_boot_r <= 1'b0;
      sampled_r     <= 1'b0;
    end
    else if (state_r == CSB_ST_SETTLE && settle_r == CSB_STRAP_SETTLE)
    begin
      loader_boot_r <= loader_pick(strap_sync);
      sampled_r     <= 1'b1;
    end
  end

  assign loader_boot_mode = loader_boot_r;
  assign boot_valid       = sampled_r;

  // programming mode and erase-all come from the control register
  logic ctrl_wr;
  logic sec_wr;
  logic erase_all;
  assign ctrl_wr   = reg_wr && hit(reg_addr, CSB_CTRL_ADDR);
  assign sec_wr    = reg_wr && hit(reg_addr, CSB_SEC_ADDR);
  assign erase_all = ctrl_wr && reg_wdata[CSB_CTL_ERASE];

  always_ff @(posedge mclk)
  begin
    if (reset)
      prog_mode_r <= 1'b0;
    else if (ctrl_wr)
      prog_mode_r <= reg_wdata[CSB_CTL_PROG];
  end

  // security bits held across reset would live in nonvolatile cells; here
  // reset stands in for the erased state
  always_ff @(posedge mclk)
  begin
    if (reset)
      sec_r <= CSB_SEC_RESET;
    else if (erase_all)
      sec_r <= CSB_SEC_RESET;
    else if (sec_wr && !prog_mode_r && sec_r[CSB_BIT_LOCK])
      sec_r <= sec_r & reg_wdata;
  end

  logic lock_on;
  assign lock_on = ~sec_r[CSB_BIT_LOCK];

  // store access refused once locked; special registers never reachable here
  assign prog_grant = prog_req && prog_mode_r && !lock_on && !prog_is_special;

  // code read steering
  always_comb
  begin
    if (!sec_r[CSB_BIT_CRI] && code_rd_from_ext)
      code_rd_internal = 1'b0;
    else
      code_rd_internal = code_rd_req && code_rd_target_int;
  end

  // port 0 scrambling: low-cost xor with a fixed key plus nibble swap
  logic [7:0] scr_data;
  assign scr_data = {port0_data_in[3:0], port0_data_in[7:4]} ^ CSB_SCRAMBLE_KEY;

  always_ff @(posedge mclk)
  begin
    if (reset)
      port0_data_out <= CSB_ZERO8;
    else if (!sec_r[CSB_BIT_SCR])
      port0_data_out <= scr_data;
    else
      port0_data_out <= port0_data_in;
  end

  assign osc_gain_half = ~sec_r[CSB_BIT_OSC];

  // read port; special registers hidden in programming mode or when locked
  logic special_ok;
  assign special_ok = !prog_mode_r && !lock_on;

  always_ff @(posedge mclk)
  begin
    if (reset)
      reg_rdata <= CSB_ZERO8;
    else if (reg_rd)
    begin
      if (hit(reg_addr, CSB_SEC_ADDR))
        reg_rdata <= special_ok ? sec_r : CSB_ZERO8;
      else if (hit(reg_addr, CSB_MAKER_ADDR))
        reg_rdata <= special_ok ? MAKER_ID : CSB_ZERO8;
      else if (hit(reg_addr, CSB_PART_ADDR))
        reg_rdata <= special_ok ? PART_ID : CSB_ZERO8;
      else if (hit(reg_addr, CSB_CTRL_ADDR))
        reg_rdata <= {6'd0, 1'b0, prog_mode_r};
      else if (hit(reg_addr, CSB_STAT_ADDR))
        reg_rdata <= {4'd0, lock_on, sampled_r, prog_mode_r, loader_boot_r};
      else
        reg_rdata <= CSB_ZERO8;
    end
    else
      reg_rdata <= CSB_ZERO8;
  end

  // checks
  sequence s_sec_write_low;
    sec_wr && !prog_mode_r && sec_r[CSB_BIT_LOCK] && !erase_all;
  endsequence

  chk_boot_decode: assert property (@(posedge mclk) disable iff (reset)
    $rose(sampled_r) |-> loader_boot_r == loader_pick($past(strap_sync)))
    else $error("boot mode does not match straps");

  chk_boot_hold: assert property (@(posedge mclk) disable iff (reset)
    sampled_r && $past(sampled_r) |-> $stable(loader_boot_r))
    else $error("boot mode changed after capture");

  chk_sec_oneway: assert property (@(posedge mclk) disable iff (reset)
    !$past(erase_all) |-> (sec_r & ~$past(sec_r)) == CSB_ZERO8)
    else $error("security bit returned to one without erase");

  chk_sec_write: assert property (@(posedge mclk) disable iff (reset)
    s_sec_write_low |=> sec_r == ($past(sec_r) & $past(reg_wdata)))
    else $error("security write not applied");

  chk_erase_all: assert property (@(posedge mclk) disable iff (reset)
    erase_all |=> sec_r == CSB_SEC_RESET)
    else $error("erase did not restore security bits");

  chk_lock_grant: assert property (@(posedge mclk) disable iff (reset)
    lock_on |-> !prog_grant)
    else $error("store access granted while locked");

  chk_prog_special: assert property (@(posedge mclk) disable iff (reset)
    prog_mode_r && reg_rd |=> reg_rdata == CSB_ZERO8 || !$past(hit(reg_addr, CSB_SEC_ADDR)))
    else $error("special register readable in programming mode");

  chk_prog_grant: assert property (@(posedge mclk) disable iff (reset)
    prog_req && prog_mode_r && !lock_on && !prog_is_special |-> prog_grant)
    else $error("unlocked programming access refused");

  chk_code_ext: assert property (@(posedge mclk) disable iff (reset)
    !sec_r[CSB_BIT_CRI] && code_rd_from_ext |-> !code_rd_internal)
    else $error("external fetch reached internal store");

  chk_code_int: assert property (@(posedge mclk) disable iff (reset)
    code_rd_req && code_rd_target_int && !code_rd_from_ext |-> code_rd_internal)
    else $error("internal fetch blocked from internal store");

  chk_code_free: assert property (@(posedge mclk) disable iff (reset)
    sec_r[CSB_BIT_CRI] && code_rd_req && code_rd_target_int |-> code_rd_internal)
    else $error("code read restricted with inhibit off");

  chk_scramble: assert property (@(posedge mclk) disable iff (reset)
    !sec_r[CSB_BIT_SCR] && !$past(reset) ##0 $past(!sec_r[CSB_BIT_SCR])
      |-> port0_data_out == ({$past(port0_data_in[3:0]), $past(port0_data_in[7:4])}
        ^ CSB_SCRAMBLE_KEY))
    else $error("port 0 data not encoded");

  chk_osc_gain: assert property (@(posedge mclk) disable iff (reset)
    osc_gain_half == !sec_r[CSB_BIT_OSC])
    else $error("oscillator gain does not follow bit 7");

  chk_maker_id: assert property (@(posedge mclk) disable iff (reset)
    reg_rd && hit(reg_addr, CSB_MAKER_ADDR) && special_ok |=> reg_rdata == MAKER_ID)
    else $error("maker identity altered");

  // one edge leaves the reset state, then the settle count runs 0 to 3;
  // the repeat below must follow CSB_STRAP_SETTLE if that count changes
  sequence s_release_wait;
    !sampled_r [*5] ##1 sampled_r;
  endsequence

  sequence s_special_read;
    reg_rd && (hit(reg_addr, CSB_SEC_ADDR) || hit(reg_addr, CSB_MAKER_ADDR)
      || hit(reg_addr, CSB_PART_ADDR));
  endsequence

  chk_settle_time: assert property (@(posedge mclk) disable iff (reset)
    $fell(reset) |-> s_release_wait)
    else $error("strap capture not on time");

  chk_valid_hold: assert property (@(posedge mclk) disable iff (reset)
    sampled_r |=> sampled_r)
    else $error("boot capture flag dropped");

  chk_boot_idle: assert property (@(posedge mclk) disable iff (reset)
    !sampled_r |-> !loader_boot_r)
    else $error("loader boot shown before capture");

  chk_rdata_idle: assert property (@(posedge mclk) disable iff (reset)
    !reg_rd |=> reg_rdata == CSB_ZERO8)
    else $error("read data present without a read");

  chk_lock_hide: assert property (@(posedge mclk) disable iff (reset)
    lock_on ##0 s_special_read |=> reg_rdata == CSB_ZERO8)
    else $error("special register readable while locked");

  chk_prog_hide: assert property (@(posedge mclk) disable iff (reset)
    prog_mode_r ##0 s_special_read |=> reg_rdata == CSB_ZERO8)
    else $error("special register readable in programming mode");

  chk_sec_refuse: assert property (@(posedge mclk) disable iff (reset)
    sec_wr && (prog_mode_r || lock_on) |=> $stable(sec_r))
    else $error("refused security write changed the bits");

  chk_lock_sticky: assert property (@(posedge mclk) disable iff (reset)
    lock_on && !erase_all |=> lock_on)
    else $error("lock released without erase");

  chk_part_id: assert property (@(posedge mclk) disable iff (reset)
    reg_rd && hit(reg_addr, CSB_PART_ADDR) && special_ok |=> reg_rdata == PART_ID)
    else $error("part identity altered");

  chk_grant_special: assert property (@(posedge mclk) disable iff (reset)
    prog_is_special |-> !prog_grant)
    else $error("programmer reached special registers");

  chk_prog_gate: assert property (@(posedge mclk) disable iff (reset)
    !prog_mode_r |-> !prog_grant)
    else $error("store access granted outside programming mode");

  chk_code_idle: assert property (@(posedge mclk) disable iff (reset)
    !code_rd_req |-> !code_rd_internal)
    else $error("internal store selected without a code read");

  chk_code_target: assert property (@(posedge mclk) disable iff (reset)
    code_rd_req && !code_rd_target_int |-> !code_rd_internal)
    else $error("external target served from internal store");

  // passthrough is checked too, so a stuck encoder cannot hide behind the key
  chk_scramble_off: assert property (@(posedge mclk) disable iff (reset)
    !$past(reset) && $past(sec_r[CSB_BIT_SCR]) |-> port0_data_out == $past(port0_data_in))
    else $error("port 0 data altered with encoding off");

  chk_gain_erase: assert property (@(posedge mclk) disable iff (reset)
    erase_all |=> !osc_gain_half)
    else $error("half gain kept after erase");

  chk_erase_unlock: assert property (@(posedge mclk) disable iff (reset)
    erase_all |=> !lock_on)
    else $error("lock kept after erase");

  chk_scr_erase: assert property (@(posedge mclk) disable iff (reset)
    erase_all |=> sec_r[CSB_BIT_SCR])
    else $error("encoding kept after erase");

endmodule : csb_code_security_boot_select

// file: bench/csb_far_model.sv
`timescale 1ns/1ps
module csb_far_model (
  input  wire logic       mclk,
  input  wire logic       prog_grant,
  output logic            prog_req,
  output logic            prog_is_special,
  output logic [7:0]      port0_data_in
);
  initial
  begin
    prog_req        = 1'b0;
    prog_is_special = 1'b0;
    port0_data_in   = 8'h00;
  end
  // request held one cycle, grant taken at the edge that sees it
  task automatic access(input logic special, output logic granted);
    @(posedge mclk);
    prog_req        <= 1'b1;
    prog_is_special <= special;
    @(posedge mclk);
    granted = prog_grant;
    prog_req        <= 1'b0;
    // released qualifier shows the inverse, never a stale value
    prog_is_special <= ~special;
  endtask : access
  // external memory puts a byte on the multiplexed bus for one cycle
  task automatic drive(input logic [7:0] d);
    @(posedge mclk);
    port0_data_in <= d;
    @(posedge mclk);
    // bus released: the inverse shows up if the byte is sampled late
    port0_data_in <= ~d;
  endtask : drive
endmodule : csb_far_model

// file: bench/csb_code_security_boot_select_tb.sv
`timescale 1ns/1ps
module csb_code_security_boot_select_tb;
  import csb_pkg::*;
  logic        mclk, reset, st_f, st_b, st_a, wr, rd, crq, cext, ctgt;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, p0_in, p0_out;
  logic        preq, pspec, grant, cint, ldr, osc, bval, g;
  int          error_cnt, total_checks;

  csb_code_security_boot_select csb_code_security_boot_select_i (
    .mclk(mclk), .reset(reset), .boot_strap_force(st_f), .boot_strap_b(st_b),
    .boot_strap_a(st_a), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata), .prog_req(preq), .prog_is_special(pspec),
    .prog_grant(grant), .code_rd_req(crq), .code_rd_from_ext(cext),
    .code_rd_target_int(ctgt), .code_rd_internal(cint), .port0_data_in(p0_in),
    .port0_data_out(p0_out), .loader_boot_mode(ldr), .osc_gain_half(osc),
    .boot_valid(bval));
  csb_far_model csb_far_model_i (.mclk(mclk), .prog_grant(grant),
    .prog_req(preq), .prog_is_special(pspec), .port0_data_in(p0_in));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk

  // straps held through reset and past capture
  task automatic boot(input logic [2:0] s);
    @(posedge mclk);
    reset <= 1'b1;
    {st_f, st_b, st_a} <= s;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    repeat (20) if (bval !== 1'b1)
    begin
      @(posedge mclk);
      #1;
    end
    chk(bval, 8'h01);
  endtask : boot

  task automatic code(input logic ext, input logic tgt, input logic [7:0] exp);
    @(posedge mclk);
    crq  <= 1'b1;
    cext <= ext;
    ctgt <= tgt;
    #1;
    chk(cint, exp);
  endtask : code

  task automatic p0(input logic [7:0] d, input logic scr);
    csb_far_model_i.drive(d);
    #1;
    chk(p0_out, scr ? ({d[3:0], d[7:4]} ^ CSB_SCRAMBLE_KEY) : d);
  endtask : p0

  initial
  begin
    #100us;
    error_cnt++;
    final_report();
  end

  initial
  begin
    {reset, st_f, st_b, st_a} = 4'b1111;
    {wr, rd, crq, cext, ctgt} = 5'b00000;
    addr  = 16'h0000;
    wdata = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      boot(i[2:0]);
      chk(ldr, !i[2] || (!i[1] && !i[0]));
    end
    // forcing levels after capture must not move the boot choice
    @(posedge mclk);
    {st_f, st_b, st_a} <= 3'b000;
    repeat (8) @(posedge mclk);
    chk(ldr, 8'h00);
    {st_f, st_b, st_a} <= 3'b111;
    rd_chk(CSB_STAT_ADDR, 8'h04);
    $display("boot strap test done");
    rd_chk(CSB_SEC_ADDR, CSB_SEC_RESET);
    wr_reg(CSB_MAKER_ADDR, 8'h00);
    rd_chk(CSB_MAKER_ADDR, CSB_MAKER_ID_DEF);
    rd_chk(CSB_PART_ADDR, CSB_PART_ID_DEF);
    rd_chk(16'h1234, 8'h00);
    wr_reg(CSB_SEC_ADDR, 8'hfd);
    wr_reg(CSB_SEC_ADDR, 8'hff);
    rd_chk(CSB_SEC_ADDR, 8'hfd);
    code(1'b1, 1'b1, 8'h00);
    code(1'b0, 1'b1, 8'h01);
    code(1'b0, 1'b0, 8'h00);
    wr_reg(CSB_CTRL_ADDR, 8'h02);
    rd_chk(CSB_SEC_ADDR, CSB_SEC_RESET);
    code(1'b1, 1'b1, 8'h01);
    $display("code read test done");
    p0(8'h12, 1'b0);
    chk(osc, 8'h00);
    wr_reg(CSB_SEC_ADDR, 8'h7b);
    p0(8'h12, 1'b1);
    chk(osc, 8'h01);
    wr_reg(CSB_SEC_ADDR, 8'hff);
    p0(8'ha7, 1'b1);
    wr_reg(CSB_CTRL_ADDR, 8'h02);
    p0(8'ha7, 1'b0);
    chk(osc, 8'h00);
    $display("scramble and gain test done");
    wr_reg(CSB_CTRL_ADDR, 8'h01);
    rd_chk(CSB_CTRL_ADDR, 8'h01);
    repeat (2)
    begin
      csb_far_model_i.access(1'b0, g);
      chk(g, 8'h01);
    end
    csb_far_model_i.access(1'b1, g);
    chk(g, 8'h00);
    rd_chk(CSB_SEC_ADDR, 8'h00);
    wr_reg(CSB_SEC_ADDR, 8'h00);
    wr_reg(CSB_CTRL_ADDR, 8'h00);
    rd_chk(CSB_SEC_ADDR, CSB_SEC_RESET);
    wr_reg(CSB_SEC_ADDR, 8'hfe);
    wr_reg(CSB_CTRL_ADDR, 8'h01);
    csb_far_model_i.access(1'b0, g);
    chk(g, 8'h00);
    rd_chk(CSB_SEC_ADDR, 8'h00);
    rd_chk(CSB_MAKER_ADDR, 8'h00);
    wr_reg(CSB_CTRL_ADDR, 8'h02);
    rd_chk(CSB_SEC_ADDR, CSB_SEC_RESET);
    $display("programming and lock test done");
    final_report();
  end
endmodule : csb_code_security_boot_select_tb
